// File: hdl/dsr_pkg.sv
// constants and carriers for the two-word burst sram core
// assumes a 25 MHz core clock sampling both link clock pins
package dsr_pkg;
   localparam int DQ_W = 18;
   localparam int LANE_W = 9;
   localparam int ADDR_W = 20;
   localparam int PAIR_W = 2 * DQ_W;
   localparam int MEM_LANES = PAIR_W / LANE_W;
   localparam int MEM_DEPTH = 1 << ADDR_W;
   // core clock period and derived timing counts
   localparam int CLK_NS = 40;
   localparam int LOCK_US = 20;
   localparam int LOCK_CYC = (LOCK_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int STOP_NS = 30;
   localparam int STOP_CYC = ((STOP_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
                             ((STOP_NS + CLK_NS - 1) / CLK_NS);
   localparam int IMP_PERIOD = 1024;
   localparam int LEGACY_MAX_MHZ = 167;
   // read latency in link half cycles
   localparam logic [2:0] LAT_PLL = 3'h5;
   localparam logic [2:0] LAT_LEGACY = 3'h2;
   localparam int SR_W = 7;
   localparam int LOCK_W = 9;
   localparam int IMP_W = 10;
   localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYC);
   localparam logic [LOCK_W-1:0] STOP_LAST = LOCK_W'(STOP_CYC);
   localparam logic [IMP_W-1:0] IMP_LAST = IMP_W'(IMP_PERIOD - 1);

   // every pin that crosses into the core clock domain
   typedef struct packed {
      logic k;
      logic k_n;
      logic load_n;
      logic rw;
      logic pll_dis_n;
      logic term_sel;
      logic [1:0] bws_n;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0] dq;
   } dsr_pin_t;

   // one write burst: address, both words, lane enables
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [PAIR_W-1:0] data;
      logic [MEM_LANES-1:0] be;
   } dsr_wr_t;
endpackage

// File: hdl/dsr_mem.sv
// lane-writable array holding one burst pair per address
// assumes a single port; caller never reads and writes together
`timescale 1ns/1ps
module dsr_mem (
   input wire logic i_core_clk,
   input wire logic i_we,
   input wire logic [dsr_pkg::ADDR_W-1:0] i_addr,
   input wire logic [dsr_pkg::PAIR_W-1:0] i_wdata,
   input wire logic [dsr_pkg::MEM_LANES-1:0] i_be,
   output logic [dsr_pkg::PAIR_W-1:0] o_rdata
);
   logic [dsr_pkg::PAIR_W-1:0] mem [dsr_pkg::MEM_DEPTH];

   // lanes with a clear enable keep their old contents
   // one process owns the whole array, so the lanes never race
   always_ff @(posedge i_core_clk) begin
      if (i_we) begin
         for (int g = 0; g < dsr_pkg::MEM_LANES; g++) begin
            if (i_be[g]) begin
               mem[i_addr][g*dsr_pkg::LANE_W +: dsr_pkg::LANE_W] <=
                  i_wdata[g*dsr_pkg::LANE_W +: dsr_pkg::LANE_W];
            end
         end
      end
   end

   // registered read, no reset so it maps onto block ram
   always_ff @(posedge i_core_clk) begin
      o_rdata <= mem[i_addr];
   end
endmodule

// File: hdl/dsr_buf.sv
// two-entry valid/ready buffer for fetched read pairs
// assumes source and sink on the same clock
`timescale 1ns/1ps
module dsr_buf #(
   parameter int W = 36
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [W-1:0] i_data,
   output logic o_valid,
   input wire logic i_ready,
   output logic [W-1:0] o_data
);
   logic [W-1:0] slot [2];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   logic push;
   logic pop;

   // honest flags straight from the fill count
   assign o_ready = (count != 2'h2);
   assign o_valid = (count != 2'h0);
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;
   assign o_data = slot[rd_ptr];

   // data slots carry no reset, only the pointers and count do
   always_ff @(posedge i_core_clk) begin
      if (push) begin
         slot[wr_ptr] <= i_data;
      end
   end

   // pointer and count bookkeeping
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr <= 1'h0;
         rd_ptr <= 1'h0;
         count <= 2'h0;
      end else begin
         wr_ptr <= wr_ptr ^ push;
         rd_ptr <= rd_ptr ^ pop;
         count <= count + {1'h0, push} - {1'h0, pop};
      end
   end
endmodule

// File: hdl/dsr_top.sv
// device-side core of a ddr two-word burst sram
// assumes link pins are asynchronous and sampled by i_core_clk
//
// Overview of operation
// R1 - read high, load low: latch read address
// R2 - every access moves two sequential words
// R3 - pll on: data 2.5 cycles after address
// R4 - controller lets every read finish
// R5 - finish reads, release bus after negative edge
// R6 - read low, load low: latch write address
// R7 - write words on next positive, negative edges
// R8 - back-to-back writes pipeline on both edges
// R9 - after writes deselect, finish then ignore
// R10 - byte selects gate each written byte
// R11 - select 0 bits 8:0, select 1 17:9
// R12 - controller idles two cycles read to write
// R13 - last write held, committed next write
// R14 - read of recent write forwards pending data
// R15 - separate load strobe per bank; core has one i_load_strobe_n and no banks
// R16 - impedance update every 1024 link cycles
// R17 - two free-running echo clocks
// R18 - valid flag leads read data half cycle
// R19 - termination range latched at power-up
// R20 - pll lock 20 us, stop 30 ns resets
// R21 - pll off: one cycle read latency
// R22 - idle after power-up, outputs released
// R23 - legacy mode limited to 167 MHz
`timescale 1ns/1ps
module dsr_top (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_link_clk,
   input wire logic i_link_clk_n,
   input wire logic i_load_strobe_n,
   input wire logic i_rw_sel,
   input wire logic [dsr_pkg::ADDR_W-1:0] i_addr,
   input wire logic [1:0] i_byte_lane_select_n,
   input wire logic [dsr_pkg::DQ_W-1:0] i_dq,
   output logic [dsr_pkg::DQ_W-1:0] o_dq,
   output logic o_dq_oe_n,
   output logic o_echo_clock,
   output logic o_echo_clock_n,
   output logic o_read_valid_flag,
   input wire logic i_pll_disable_n,
   input wire logic i_termination_range_sel,
   output logic o_term_high_range,
   output logic o_imp_update,
   output logic o_pll_locked
);
   dsr_pkg::dsr_pin_t raw, s1, s2, s3, pin, pin_q;
   logic kr, kbr, tick;
   logic pll_en, acc_ok, rd_start, wr_start;
   logic [dsr_pkg::LOCK_W-1:0] lock_cnt, stop_cnt;
   logic pll_stop;
   logic [dsr_pkg::IMP_W-1:0] imp_cnt;
   logic term_done;
   logic [dsr_pkg::ADDR_W-1:0] addr_q;
   logic data_due, phase1;
   dsr_pkg::dsr_wr_t cap, post;
   logic post_valid;
   logic mem_we;
   logic [dsr_pkg::PAIR_W-1:0] mem_rdata;
   logic fetch_pend, fetch_go, fetch_q;
   logic [dsr_pkg::ADDR_W-1:0] fetch_addr;
   logic hit_q;
   dsr_pkg::dsr_wr_t hit_wr;
   logic [dsr_pkg::PAIR_W-1:0] merged;
   logic buf_in_ready, buf_out_valid;
   logic [dsr_pkg::PAIR_W-1:0] buf_out;
   logic [dsr_pkg::SR_W-1:0] rd_sr, next_rd_sr;
   logic [2:0] lat;
   logic launch_w0, launch_w1, next_flag;
   logic [dsr_pkg::DQ_W-1:0] w1_hold;

   // all pins sampled together so data lines up with edges
   assign raw = {i_link_clk, i_link_clk_n, i_load_strobe_n, i_rw_sel,
                 i_pll_disable_n, i_termination_range_sel,
                 i_byte_lane_select_n, i_addr, i_dq};

   // three-flop sampler; a bit moves once stages two and three agree
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         pin <= '0;
         pin_q <= '0;
      end else begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
         pin <= dsr_pkg::dsr_pin_t'((s2 & s3) | (pin & (s2 ^ s3)));
         pin_q <= pin;
      end
   end

   // rising edges of both link clocks, each a half-cycle tick
   assign kr = pin.k && !pin_q.k;
   assign kbr = pin.k_n && !pin_q.k_n;
   assign tick = kr || kbr;
   assign pll_en = pin.pll_dis_n;

   // clock stopped when both pins sit at the same level
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stop_cnt <= '0;
      end else if (pin.k != pin.k_n) begin
         stop_cnt <= '0;
      end else if (stop_cnt != dsr_pkg::STOP_LAST) begin
         stop_cnt <= stop_cnt + 1'h1;
      end
   end
   assign pll_stop = (stop_cnt == dsr_pkg::STOP_LAST); // see R20

   // lock after a run of stable clock, lost on any stop
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lock_cnt <= '0;
      end else if (pll_stop) begin
         lock_cnt <= '0; // see R20
      end else if (lock_cnt != dsr_pkg::LOCK_LAST) begin
         lock_cnt <= lock_cnt + 1'h1;
      end
   end
   assign o_pll_locked = (lock_cnt == dsr_pkg::LOCK_LAST);

   // loads are ignored until the pll has locked, unless bypassed
   assign acc_ok = !pll_en || o_pll_locked; // see R20 R21
   assign rd_start = kr && acc_ok && !pin.load_n && pin.rw; // see R1
   assign wr_start = kr && acc_ok && !pin.load_n && !pin.rw; // see R6

   // echo clocks follow the filtered input clocks, free running
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_echo_clock <= 1'h0;
         o_echo_clock_n <= 1'h0;
      end else begin
         o_echo_clock <= pin.k; // see R17
         o_echo_clock_n <= pin.k_n; // see R17
      end
   end

   // impedance retune strobe once per 1024 positive link edges
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         imp_cnt <= '0;
         o_imp_update <= 1'h0;
      end else begin
         o_imp_update <= kr && (imp_cnt == dsr_pkg::IMP_LAST); // see R16
         if (kr) begin
            imp_cnt <= imp_cnt + 1'h1;
         end
      end
   end

   // range pin caught once, after the sampler has filled
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         term_done <= 1'h0;
         o_term_high_range <= 1'h1;
      end else if (!term_done && kr) begin
         term_done <= 1'h1;
         o_term_high_range <= pin.term_sel; // see R19
      end
   end

   // write address queued one cycle while its data arrives
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         addr_q <= '0;
         data_due <= 1'h0;
      end else if (kr) begin
         addr_q <= pin.addr; // see R6
         data_due <= wr_start; // see R8 R9
      end
   end

   // assemble the burst: word0 on positive, word1 on negative edge
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cap <= '0;
         phase1 <= 1'h0;
      end else if (kr && data_due) begin
         cap.addr <= addr_q; // see R7
         cap.data[dsr_pkg::DQ_W-1:0] <= pin.dq;
         cap.be[1:0] <= ~pin.bws_n; // see R10 R11
         phase1 <= 1'h1;
      end else if (kbr && phase1) begin
         cap.data[dsr_pkg::PAIR_W-1:dsr_pkg::DQ_W] <= pin.dq; // see R2
         cap.be[3:2] <= ~pin.bws_n; // see R10 R11
         phase1 <= 1'h0;
      end
   end

   // completed burst is posted; the older one goes to the array
   assign mem_we = kbr && phase1 && post_valid; // see R13
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         post <= '0;
         post_valid <= 1'h0;
      end else if (kbr && phase1) begin
         post <= cap;
         post.data[dsr_pkg::PAIR_W-1:dsr_pkg::DQ_W] <= pin.dq; // see R7
         post.be[3:2] <= ~pin.bws_n;
         post_valid <= 1'h1; // see R13
      end
   end

   // one array port: posted commit or read fetch, never both
   dsr_mem u_mem (
      .i_core_clk(i_core_clk),
      .i_we(mem_we),
      .i_addr(mem_we ? post.addr : fetch_addr),
      .i_wdata(post.data),
      .i_be(post.be),
      .o_rdata(mem_rdata)
   );

   // fetch waits for a burst still arriving and for buffer room
   assign fetch_go = fetch_pend && !data_due && !phase1 &&
                     !mem_we && buf_in_ready; // see R14
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fetch_pend <= 1'h0;
         fetch_addr <= '0;
      end else if (rd_start) begin
         fetch_pend <= 1'h1;
         fetch_addr <= pin.addr; // see R1
      end else if (fetch_go) begin
         fetch_pend <= 1'h0;
      end
   end

   // note the posted burst at fetch time for forwarding
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fetch_q <= 1'h0;
         hit_q <= 1'h0;
         hit_wr <= '0;
      end else begin
         fetch_q <= fetch_go;
         hit_q <= post_valid && (post.addr == fetch_addr); // see R14
         hit_wr <= post;
      end
   end

   // newest data wins lane by lane over the array contents
   always_comb begin
      merged = mem_rdata;
      for (int i = 0; i < dsr_pkg::MEM_LANES; i++) begin
         if (hit_q && hit_wr.be[i]) begin
            merged[i*dsr_pkg::LANE_W +: dsr_pkg::LANE_W] =
               hit_wr.data[i*dsr_pkg::LANE_W +: dsr_pkg::LANE_W];
         end
      end
   end

   // two slots ride out back-to-back reads; full stalls the fetch
   dsr_buf #(
      .W(dsr_pkg::PAIR_W)
   ) u_buf (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_valid(fetch_q),
      .o_ready(buf_in_ready),
      .i_data(merged),
      .o_valid(buf_out_valid),
      .i_ready(launch_w0),
      .o_data(buf_out)
   );

   // read launch timing counted in link half cycles
   // legacy latency is only guaranteed up to 167 MHz
   assign lat = pll_en ? dsr_pkg::LAT_PLL : dsr_pkg::LAT_LEGACY; // see R3 R21
   always_comb begin
      next_rd_sr = rd_sr;
      if (tick) begin
         next_rd_sr = {rd_sr[dsr_pkg::SR_W-2:0], rd_start};
      end
   end
   assign launch_w0 = tick && next_rd_sr[lat]; // see R3 R23
   assign launch_w1 = tick && next_rd_sr[lat + 3'h1]; // see R2
   assign next_flag = next_rd_sr[lat - 3'h1] || next_rd_sr[lat]; // see R18

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_sr <= '0;
      end else begin
         rd_sr <= next_rd_sr;
      end
   end

   // output stage: drive while words launch, release on negative edge
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_dq <= '0;
         o_dq_oe_n <= 1'h1; // see R22
         w1_hold <= '0;
         o_read_valid_flag <= 1'h0;
      end else begin
         if (tick) begin
            o_read_valid_flag <= next_flag; // see R18
         end
         if (launch_w0) begin
            o_dq <= buf_out[dsr_pkg::DQ_W-1:0]; // see R3
            w1_hold <= buf_out[dsr_pkg::PAIR_W-1:dsr_pkg::DQ_W];
            o_dq_oe_n <= 1'h0;
         end else if (launch_w1) begin
            o_dq <= w1_hold; // see R2
            o_dq_oe_n <= 1'h0;
         end else if (kbr) begin
            o_dq_oe_n <= 1'h1; // see R5
         end
      end
   end

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   rd_capture_a: assert property (rd_start |=> fetch_pend && // see R1
      fetch_addr == $past(pin.addr))
      else $error("read address not latched");
   wr_capture_a: assert property (wr_start |=> data_due && // see R6
      addr_q == $past(pin.addr))
      else $error("write address not latched");
   word0_drive_a: assert property (launch_w0 |=> !o_dq_oe_n && // see R3
      o_dq == $past(buf_out[dsr_pkg::DQ_W-1:0]))
      else $error("first read word not driven");
   bus_release_a: assert property (kbr && !launch_w0 && // see R5
      !launch_w1 |=> o_dq_oe_n)
      else $error("bus not released after negative edge");
   flag_lead_a: assert property ($rose(o_read_valid_flag) |-> // see R18
      ##[1:6] launch_w0)
      else $error("valid flag not followed by data");
   lane_mask_a: assert property (kr && data_due && // see R11
      (&pin.bws_n) |=> cap.be[1:0] == 2'h0)
      else $error("deselected lanes still enabled");
   echo_follow_a: assert property (o_echo_clock == $past(pin.k) && // see R17
      o_echo_clock_n == $past(pin.k_n))
      else $error("echo clock does not follow input clock");
   imp_pulse_a: assert property (o_imp_update |-> // see R16
      $past(imp_cnt) == dsr_pkg::IMP_LAST ##1 !o_imp_update)
      else $error("impedance strobe mistimed");
   port_share_a: assert property (fetch_go |-> !mem_we && // see R13
      !phase1)
      else $error("fetch collides with posted write");
   lock_gate_a: assert property (!acc_ok |-> !rd_start && // see R20
      !wr_start)
      else $error("access accepted before lock");

   rd_burst_c: cover property (rd_start ##[1:60] launch_w1);
   wr_back_c: cover property (wr_start ##[1:12] wr_start);
   bypass_c: cover property (fetch_q && hit_q);
   buf_full_c: cover property (fetch_pend && !buf_in_ready);
endmodule

// File: sim/dsr_ctl_model.sv
// controller model: link clocks, command pins, write data, read capture
// assumes the bench fills opq and takes captured reads from rdq
`timescale 1ns/1ps
module dsr_ctl_model (
   input wire logic i_core_clk,
   input wire logic i_run,
   input wire logic i_lat1,
   output logic o_k,
   output logic o_k_n,
   output logic o_load_n,
   output logic o_rw,
   output logic [dsr_pkg::ADDR_W-1:0] o_addr,
   output logic [1:0] o_bws_n,
   output logic [dsr_pkg::DQ_W-1:0] o_dq,
   input wire logic [dsr_pkg::DQ_W-1:0] i_dq,
   input wire logic i_oe_n,
   input wire logic i_flag
);
   typedef struct packed {
      logic go;
      logic rd;
      logic [dsr_pkg::ADDR_W-1:0] addr;
      logic [3:0] bws_n;
      logic [dsr_pkg::PAIR_W-1:0] data;
   } dsr_op_t;
   dsr_op_t opq[$];
   logic [dsr_pkg::PAIR_W+1:0] rdq[$];
   dsr_op_t cur, nxt;
   logic cur_v, nxt_v;

   // free-running link clock; both pins park high while stopped
   initial begin
      {o_k, o_k_n, o_load_n, o_rw} = 4'h7;
      {o_addr, o_bws_n, o_dq} = '0;
      {cur_v, nxt_v, cur, nxt} = '0;
      #7;
      forever begin
         #160;
         if (i_run) begin
            o_k = ~o_k;
            o_k_n = ~o_k;
         end else begin
            {o_k, o_k_n} = 2'h3; // stop resets lock
         end
      end
   end

   // word0 mid-burst sample, word1 one half edge later; reads run whole
   task automatic grab();
      logic [dsr_pkg::DQ_W-1:0] w0;
      logic f, e;
      repeat (i_lat1 ? 2 : 5) @(posedge o_k or posedge o_k_n);
      repeat (3) @(negedge i_core_clk);
      {w0, f, e} = {i_dq, i_flag, i_oe_n};
      @(posedge o_k or posedge o_k_n);
      repeat (3) @(negedge i_core_clk);
      rdq.push_back({f, e | i_oe_n, i_dq, w0});
   endtask

   // mid-cycle: next command for the coming rise, word0 of last write
   // pins change late in the half cycle, clear of the core's first sample
   always @(posedge o_k_n) begin
      repeat (3) @(negedge i_core_clk);
      {cur, cur_v} = {nxt, nxt_v};
      nxt_v = (opq.size() > 0);
      if (nxt_v)
         nxt = opq.pop_front();
      nxt_v = nxt_v && nxt.go;
      o_load_n = !nxt_v;
      o_rw = nxt.rd;
      o_addr = nxt.addr;
      if (cur_v && !cur.rd)
         {o_dq, o_bws_n} = {cur.data[17:0], cur.bws_n[1:0]};
      else
         o_dq = ~o_dq; // released bus never repeats the last word
      if (cur_v && cur.rd)
         fork
            grab();
         join_none
   end

   // positive rise after word0: second write word
   always @(posedge o_k) begin
      repeat (3) @(negedge i_core_clk);
      if (cur_v && !cur.rd)
         {o_dq, o_bws_n} = {cur.data[35:18], cur.bws_n[3:2]};
   end
endmodule

// File: sim/dsr_top_tb.sv
// self-checking bench for the burst sram core
// assumes the controller model makes the link clock and pins
`timescale 1ns/1ps
module dsr_top_tb;
   logic core_clk, rst_n, pll_dis_n, term_sel, run, k, k_n, load_n, rw;
   logic oe_n, echo, echo_n, flag, term_hi, imp, locked, kp;
   logic [dsr_pkg::ADDR_W-1:0] addr;
   logic [1:0] bws_n;
   logic [dsr_pkg::DQ_W-1:0] m_dq, d_dq, dq;
   logic [dsr_pkg::PAIR_W-1:0] mem [logic [dsr_pkg::ADDR_W-1:0]];
   logic [dsr_pkg::PAIR_W+1:0] expq[$];
   int fails, check_count, n, kc;
   int cyc = 0;

   // device wins the shared data pin whenever it drives
   assign dq = !oe_n ? d_dq : m_dq;

   dsr_ctl_model dsr_ctl_model_i (.i_core_clk(core_clk), .i_run(run),
      .i_lat1(!pll_dis_n), .o_k(k), .o_k_n(k_n), .o_load_n(load_n),
      .o_rw(rw), .o_addr(addr), .o_bws_n(bws_n), .o_dq(m_dq), .i_dq(dq),
      .i_oe_n(oe_n), .i_flag(flag));

   dsr_top dsr_top_i (.i_core_clk(core_clk), .i_rst_n(rst_n),
      .i_link_clk(k), .i_link_clk_n(k_n), .i_load_strobe_n(load_n),
      .i_rw_sel(rw), .i_addr(addr), .i_byte_lane_select_n(bws_n),
      .i_dq(dq), .o_dq(d_dq), .o_dq_oe_n(oe_n), .o_echo_clock(echo),
      .o_echo_clock_n(echo_n), .o_read_valid_flag(flag),
      .i_pll_disable_n(pll_dis_n), .i_termination_range_sel(term_sel),
      .o_term_high_range(term_hi), .o_imp_update(imp),
      .o_pll_locked(locked));

   // core clock, 40 ns
   initial begin
      core_clk = 1'h0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic complete_run();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // hang guard, well above the expected run length
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails++;
         complete_run();
      end
   end

   task automatic cmp(input string what,
      input logic [dsr_pkg::PAIR_W+1:0] e, input logic [dsr_pkg::PAIR_W+1:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic cmpb(input string what, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask

   // write burst; lanes with a high select keep the old contents
   task automatic wr(input logic [dsr_pkg::ADDR_W-1:0] a,
      input logic [dsr_pkg::PAIR_W-1:0] d, input logic [3:0] b);
      for (int i = 0; i < 4; i++)
         if (!b[i])
            mem[a][i*9 +: 9] = d[i*9 +: 9];
      dsr_ctl_model_i.opq.push_back({1'h1, 1'h0, a, b, d});
   endtask

   // read burst: flag high during word0 and bus driven through both words expected
   task automatic rd(input logic [dsr_pkg::ADDR_W-1:0] a);
      expq.push_back({1'h1, 1'h0, mem[a]});
      dsr_ctl_model_i.opq.push_back({1'h1, 1'h1, a, 4'hf, 36'h0});
   endtask

   task automatic nop();
      dsr_ctl_model_i.opq.push_back('0);
   endtask

   task automatic drain();
      n = 0;
      while (dsr_ctl_model_i.rdq.size() < expq.size() && n < 800) begin
         @(negedge core_clk);
         n++;
      end
      while (expq.size() > 0)
         cmp("read pair", expq.pop_front(), dsr_ctl_model_i.rdq.size() > 0 ?
            dsr_ctl_model_i.rdq.pop_front() : 'x);
   endtask

   task automatic wait_lock();
      n = 0;
      while (locked !== 1'h1 && n < 700) begin
         @(negedge core_clk);
         n++;
      end
      cmpb("locked", 1'h1, locked);
   endtask

   // main sequence: pll mode traffic, then legacy mode after reset
   initial begin
      {rst_n, pll_dis_n, term_sel, run, kp} = 5'h0e;
      {fails, check_count} = '0;
      repeat (5) @(negedge core_clk);
      cmpb("oe_n in reset", 1'h1, oe_n);
      rst_n = 1'h1;
      repeat (400) @(negedge core_clk);
      cmpb("lock early", 1'h0, locked);
      cmpb("range high", 1'h1, term_hi);
      cmpb("idle bus", 1'h1, oe_n);
      wait_lock();
      @(posedge k_n);
      repeat (3) @(negedge core_clk);
      cmpb("echo", 1'h1, echo);
      cmpb("echo_n", 1'h0, echo_n);
      wr(20'h00010, 36'h123456789, 4'h0);
      rd(20'h00010);
      // third idle: the core releases the bus late in the half cycle
      nop();
      nop();
      nop();
      wr(20'h00010, 36'hfedcba987, 4'he);
      wr(20'h00011, 36'h0aaaa5555, 4'h0);
      wr(20'h00011, 36'h3c3c3c3c3, 4'h3);
      rd(20'h00010);
      rd(20'h00011);
      rd(20'h00010);
      nop();
      nop();
      nop();
      wr(20'h00012, 36'h5a5a5a5a5, 4'h0);
      rd(20'h00011);
      rd(20'h00012);
      drain();
      repeat (20) @(negedge core_clk);
      cmpb("bus released", 1'h1, oe_n);
      run = 1'h0;
      repeat (12) @(negedge core_clk);
      cmpb("lock after stop", 1'h0, locked);
      run = 1'h1;
      wait_lock();
      n = 0;
      while (imp !== 1'h1 && n < 9000) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      kc = 0;
      n = 0;
      while (imp !== 1'h1 && n < 9000) begin
         @(negedge core_clk);
         n++;
         kc += (k && !kp);
         kp = k;
      end
      cmp("imp period", 38'h400, 38'(kc));
      {rst_n, pll_dis_n, term_sel} = 3'h0;
      repeat (5) @(negedge core_clk);
      cmpb("range in reset", 1'h1, term_hi);
      rst_n = 1'h1;
      repeat (40) @(negedge core_clk);
      cmpb("range low", 1'h0, term_hi);
      wr(20'h00020, 36'h0f0f0f0f0, 4'h0);
      wr(20'h00021, 36'h987654321, 4'h0);
      rd(20'h00020);
      rd(20'h00021);
      drain();
      complete_run();
   end
endmodule
